/* File: pkg/jcc_pkg.sv */
/*
 * jcc_pkg: shared constants and carrier types of the justification count codec.
 * assumes a single frame clock domain; byte bit 1 is the msb and is sent first.
 */
package jcc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CNT_W     = 14;
	localparam int NARROW_W  = 10;
	localparam int CRC8_W    = 8;
	localparam int CRC6_W    = 6;
	localparam int MSG8_W    = 16;
	localparam int MSG6_W    = 12;
	localparam int NPAT      = 4;

	// ----------------------------------------------------------------
	// crc generators, x^n term implied
	// ----------------------------------------------------------------
	localparam logic [CRC8_W-1:0] CRC8_POLY = 8'h0d;
	localparam logic [CRC6_W-1:0] CRC6_POLY = 6'h0d;

	// ----------------------------------------------------------------
	// inversion masks, count_bit 1 is the msb; order +1, -1, +2, -2
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] INV14 [NPAT] = '{14'h2aaa, 14'h1555, 14'h1999, 14'h2666};
	localparam logic [CNT_W-1:0] INV10 [NPAT] = '{14'h02aa, 14'h0259, 14'h0165, 14'h0196};
	// flag pair {increment_flag, decrement_flag} for each pattern
	localparam logic [1:0]       PAT_FLAGS [NPAT] = '{2'h2, 2'h1, 2'h2, 2'h1};
	localparam logic signed [2:0] PAT_STEP [NPAT] = '{3'sh1, -3'sh1, 3'sh2, -3'sh2};

	// count bits carried by byte a, the rest travel in byte b
	localparam logic [CNT_W-1:0] BYTE_A_BITS14 = 14'h3fc0;
	localparam logic [CNT_W-1:0] BYTE_A_BITS10 = 14'h03f0;
	localparam logic [CNT_W-1:0] WIDE_BITS     = 14'h3fff;
	localparam logic [CNT_W-1:0] NARROW_BITS   = 14'h03ff;

	// ----------------------------------------------------------------
	// flag encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] FLAGS_NONE = 2'h0;
	localparam logic [1:0] FLAGS_INC  = 2'h2;
	localparam logic [1:0] FLAGS_DEC  = 2'h1;
	localparam logic [1:0] FLAGS_NEW  = 2'h3;
	localparam logic [1:0] PAD2       = 2'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] just_ctrl_byte_a;
		logic [7:0] just_ctrl_byte_b;
		logic [7:0] just_ctrl_check_byte;
	} jcc_bytes_s;

	typedef enum logic {
		JCC_HUNT,
		JCC_SYNC
	} jcc_sync_e;

endpackage

/* File: design/jcc_crc_rem.sv */
/*
 * jcc_crc_rem: combinational remainder of a message polynomial modulo a generator.
 * assumes the caller appends zero bits for generation or the received check bits for checking.
 */
`timescale 1ns/10ps
module jcc_crc_rem #(
	parameter int               MSG_W = 16,
	parameter int               REM_W = 8,
	parameter logic [REM_W-1:0] POLY  = '0
) (
	input  wire logic [MSG_W-1:0] msg,
	output logic      [REM_W-1:0] rem
);

	// ----------------------------------------------------------------
	// long division, msb first
	// ----------------------------------------------------------------
	always_comb begin
		logic fb;
		fb  = 1'b0;
		rem = '0;
		for (int i = MSG_W - 1; i >= 0; i--) begin
			fb  = rem[REM_W-1];
			rem = {rem[REM_W-2:0], msg[i]};
			if (fb) begin
				rem = rem ^ POLY;
			end
		end
	end

endmodule

/* File: design/jcc_codec.sv */
/*
 * jcc_codec: encoder and decoder of the per-frame entity count in three justification bytes.
 * assumes frame strobes come from logic on mclk; count_mode is static between frames.
 */
`timescale 1ns/10ps
module jcc_codec #(
	parameter int CW = jcc_pkg::CNT_W
) (
	input  wire logic               mclk,
	input  wire logic               arst_n,
	input  wire logic               clk_en,
	input  wire logic               count_mode,
	input  wire logic               enc_frame,
	input  wire logic [CW-1:0]      enc_count,
	input  wire logic               dec_frame,
	input  wire jcc_pkg::jcc_bytes_s dec_bytes,
	output jcc_pkg::jcc_bytes_s     enc_bytes,
	output logic                    enc_valid,
	output logic [CW-1:0]           dec_count,
	output logic                    dec_valid,
	output logic                    dec_crc_ok,
	output logic                    dec_synced
);

	// ----------------------------------------------------------------
	// encoder: step against the reference
	// ----------------------------------------------------------------
	logic [CW-1:0]        enc_ref_r;
	logic [CW-1:0]        enc_ref_nxt;
	logic [CW-1:0]        width_bits;
	logic [CW-1:0]        enc_new;
	logic [CW:0]          enc_diff;
	logic                 step_zero;
	logic                 step_p1;
	logic                 step_m1;
	logic                 step_p2;
	logic                 step_m2;
	logic [CW-1:0]        inv_p1;
	logic [CW-1:0]        inv_m1;
	logic [CW-1:0]        inv_p2;
	logic [CW-1:0]        inv_m2;
	logic [CW-1:0]        tx_count;
	logic [1:0]           tx_flags;
	logic [7:0]           tx_a;
	logic [7:0]           tx_b;
	logic [7:0]           tx_check;
	logic [7:0]           crc8_tx;
	logic [5:0]           crc6_tx;
	jcc_pkg::jcc_bytes_s  enc_bytes_nxt;

	assign width_bits = count_mode ? jcc_pkg::NARROW_BITS : jcc_pkg::WIDE_BITS;
	// count taken as unsigned, trimmed to the field
	assign enc_new    = enc_count & width_bits;
	assign enc_diff   = {1'b0, enc_new} - {1'b0, enc_ref_r};
	// only nonzero steps of at most two invert
	assign step_zero  = (enc_diff == (CW+1)'(0));
	assign step_p1    = (enc_diff == (CW+1)'(1));
	assign step_p2    = (enc_diff == (CW+1)'(2));
	assign step_m1    = (enc_diff == {(CW+1){1'b1}});
	assign step_m2    = (enc_diff == {{CW{1'b1}}, 1'b0});

	assign inv_p1 = count_mode ? jcc_pkg::INV10[0] : jcc_pkg::INV14[0];
	assign inv_m1 = count_mode ? jcc_pkg::INV10[1] : jcc_pkg::INV14[1];
	assign inv_p2 = count_mode ? jcc_pkg::INV10[2] : jcc_pkg::INV14[2];
	assign inv_m2 = count_mode ? jcc_pkg::INV10[3] : jcc_pkg::INV14[3];

	always_comb begin
		tx_count = enc_ref_r;
		tx_flags = jcc_pkg::FLAGS_NONE;
		if (step_p1) begin
			tx_count = enc_ref_r ^ inv_p1;
			tx_flags = jcc_pkg::FLAGS_INC;
		end else if (step_p2) begin
			tx_count = enc_ref_r ^ inv_p2;
			tx_flags = jcc_pkg::FLAGS_INC;
		end else if (step_m1) begin
			tx_count = enc_ref_r ^ inv_m1;
			tx_flags = jcc_pkg::FLAGS_DEC;
		end else if (step_m2) begin
			tx_count = enc_ref_r ^ inv_m2;
			tx_flags = jcc_pkg::FLAGS_DEC;
		end else if (!step_zero) begin
			tx_count = enc_new;
			tx_flags = jcc_pkg::FLAGS_NEW;
		end
	end

	// narrow field leaves bits 1-2 of each byte at zero
	assign tx_a = count_mode ? {jcc_pkg::PAD2, tx_count[9:4]} : tx_count[13:6];
	assign tx_b = count_mode ? {jcc_pkg::PAD2, tx_count[3:0], tx_flags} : {tx_count[5:0], tx_flags};

	jcc_crc_rem #(
		.MSG_W (jcc_pkg::MSG8_W + jcc_pkg::CRC8_W),
		.REM_W (jcc_pkg::CRC8_W),
		.POLY  (jcc_pkg::CRC8_POLY)
	) u_crc8_tx (
		.msg ({tx_a, tx_b, 8'h00}),
		.rem (crc8_tx)
	);

	jcc_crc_rem #(
		.MSG_W (jcc_pkg::MSG6_W + jcc_pkg::CRC6_W),
		.REM_W (jcc_pkg::CRC6_W),
		.POLY  (jcc_pkg::CRC6_POLY)
	) u_crc6_tx (
		.msg ({tx_a[5:0], tx_b[5:0], 6'h00}),
		.rem (crc6_tx)
	);

	// x^7 lands in bit 1, sent first
	assign tx_check      = count_mode ? {jcc_pkg::PAD2, crc6_tx} : crc8_tx;
	assign enc_bytes_nxt = '{just_ctrl_byte_a: tx_a, just_ctrl_byte_b: tx_b, just_ctrl_check_byte: tx_check};
	// the new count is the next reference
	assign enc_ref_nxt   = enc_frame ? enc_new : enc_ref_r;

	// ----------------------------------------------------------------
	// decoder: field extraction and crc check
	// ----------------------------------------------------------------
	logic [CW-1:0]        rx_count;
	logic [1:0]           rx_flags;
	logic [7:0]           rem8_rx;
	logic [5:0]           rem6_rx;
	logic                 rx_crc_ok;
	logic [CW-1:0]        rx_diff;
	logic [CW-1:0]        byte_a_bits;
	logic [CW-1:0]        byte_b_bits;
	logic [jcc_pkg::NPAT-1:0] hit_all;
	logic [jcc_pkg::NPAT-1:0] hit_a;
	logic [jcc_pkg::NPAT-1:0] hit_b;

	assign rx_count = count_mode ?
		{4'h0, dec_bytes.just_ctrl_byte_a[5:0], dec_bytes.just_ctrl_byte_b[5:2]} :
		{dec_bytes.just_ctrl_byte_a, dec_bytes.just_ctrl_byte_b[7:2]};
	assign rx_flags = dec_bytes.just_ctrl_byte_b[1:0];

	jcc_crc_rem #(
		.MSG_W (jcc_pkg::MSG8_W + jcc_pkg::CRC8_W),
		.REM_W (jcc_pkg::CRC8_W),
		.POLY  (jcc_pkg::CRC8_POLY)
	) u_crc8_rx (
		.msg ({dec_bytes.just_ctrl_byte_a, dec_bytes.just_ctrl_byte_b, dec_bytes.just_ctrl_check_byte}),
		.rem (rem8_rx)
	);

	jcc_crc_rem #(
		.MSG_W (jcc_pkg::MSG6_W + jcc_pkg::CRC6_W),
		.REM_W (jcc_pkg::CRC6_W),
		.POLY  (jcc_pkg::CRC6_POLY)
	) u_crc6_rx (
		.msg ({dec_bytes.just_ctrl_byte_a[5:0], dec_bytes.just_ctrl_byte_b[5:0],
			dec_bytes.just_ctrl_check_byte[5:0]}),
		.rem (rem6_rx)
	);

	assign rx_crc_ok   = count_mode ? (rem6_rx == 6'h00) : (rem8_rx == 8'h00);
	assign rx_diff     = rx_count ^ dec_count;
	assign byte_a_bits = count_mode ? jcc_pkg::BYTE_A_BITS10 : jcc_pkg::BYTE_A_BITS14;
	assign byte_b_bits = width_bits & ~byte_a_bits;

	// ----------------------------------------------------------------
	// per pattern match against the expected count
	// ----------------------------------------------------------------
	generate
		for (genvar k = 0; k < jcc_pkg::NPAT; k++) begin : g_pat
			logic [CW-1:0] mask;
			logic [CW-1:0] err;
			assign mask       = count_mode ? jcc_pkg::INV10[k] : jcc_pkg::INV14[k];
			assign err        = rx_diff ^ mask;
			assign hit_all[k] = (err == '0) && (rx_flags == jcc_pkg::PAT_FLAGS[k]);
			assign hit_a[k]   = ((err & byte_a_bits) == '0);
			assign hit_b[k]   = ((err & byte_b_bits) == '0) && (rx_flags == jcc_pkg::PAT_FLAGS[k]);
		end
	endgenerate

	// lowest index wins; masks never overlap inside one byte in practice
	function automatic logic [1:0] first_hit(input logic [jcc_pkg::NPAT-1:0] v);
		first_hit = 2'h0;
		for (int i = jcc_pkg::NPAT - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_hit = 2'(i);
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// decoder: sync decision
	// ----------------------------------------------------------------
	jcc_pkg::jcc_sync_e   sync_r;
	jcc_pkg::jcc_sync_e   sync_nxt;
	logic [CW-1:0]        dcnt_nxt;
	logic                 use_step;
	logic [1:0]           step_idx;
	logic [1:0]           idx_a;
	logic [1:0]           idx_b;
	logic [CW-1:0]        stepped;

	assign idx_a   = first_hit(hit_a);
	assign idx_b   = first_hit(hit_b);
	assign stepped = (dec_count + CW'(signed'(jcc_pkg::PAT_STEP[step_idx]))) & width_bits;

	always_comb begin
		sync_nxt = sync_r;
		use_step = 1'b0;
		step_idx = 2'h0;
		dcnt_nxt = dec_count;
		if (rx_crc_ok && (rx_flags[1] == rx_flags[0])) begin
			dcnt_nxt = rx_count;
			sync_nxt = jcc_pkg::JCC_SYNC;
		end else if (sync_r == jcc_pkg::JCC_SYNC) begin
			case ({rx_crc_ok, |hit_a, |hit_b})
				3'b100, 3'b101, 3'b110, 3'b111: begin
					use_step = |hit_all;
					step_idx = first_hit(hit_all);
					sync_nxt = (|hit_all) ? jcc_pkg::JCC_SYNC : jcc_pkg::JCC_HUNT;
				end
				3'b010: begin
					use_step = 1'b1;
					step_idx = idx_a;
				end
				3'b001: begin
					use_step = 1'b1;
					step_idx = idx_b;
				end
				3'b011: begin
					// disagreeing copies are not trusted
					use_step = (idx_a == idx_b);
					step_idx = idx_a;
					sync_nxt = (idx_a == idx_b) ? jcc_pkg::JCC_SYNC : jcc_pkg::JCC_HUNT;
				end
				default: begin
					sync_nxt = jcc_pkg::JCC_HUNT;
				end
			endcase
			if (use_step) begin
				dcnt_nxt = stepped;
			end
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			enc_ref_r  <= '0;
			enc_bytes  <= '0;
			enc_valid  <= 1'b0;
		end else if (clk_en) begin
			enc_ref_r  <= enc_ref_nxt;
			enc_valid  <= enc_frame;
			if (enc_frame) begin
				enc_bytes <= enc_bytes_nxt;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync_r     <= jcc_pkg::JCC_HUNT;
			dec_count  <= '0;
			dec_valid  <= 1'b0;
			dec_crc_ok <= 1'b0;
		end else if (clk_en) begin
			dec_valid  <= dec_frame;
			if (dec_frame) begin
				sync_r     <= sync_nxt;
				dec_count  <= dcnt_nxt;
				dec_crc_ok <= rx_crc_ok;
			end
		end
	end

	assign dec_synced = (sync_r == jcc_pkg::JCC_SYNC);

endmodule

/* File: tb/jcc_peer_model.sv */
/*
 * jcc_peer_model: far-end mapper that packs a count field and flags into three bytes.
 * assumes the bench settles field and flags before sampling bytes.
 */
`timescale 1ns/10ps
module jcc_peer_model (
	input  wire logic          count_mode,
	input  wire logic [13:0]   field,
	input  wire logic [1:0]    flags,
	output jcc_pkg::jcc_bytes_s bytes
);
	logic [15:0] msg;
	logic [7:0]  crc;

	// ----------------------------------------------------------------
	// framing and check byte
	// ----------------------------------------------------------------
	// pack, then crc
	always_comb begin
		bytes.just_ctrl_byte_a = count_mode ? {2'h0, field[9:4]} : field[13:6];
		bytes.just_ctrl_byte_b = count_mode ? {2'h0, field[3:0], flags} : {field[5:0], flags};
		msg = {bytes.just_ctrl_byte_a, bytes.just_ctrl_byte_b};
		if (count_mode)
			msg = {bytes.just_ctrl_byte_a[5:0], bytes.just_ctrl_byte_b[5:0], 4'h0};
		crc = 8'h00;
		// bitwise lfsr division is slow but independent of the design's appended-zero long division form
		for (int i = 15; i >= 0; i--) begin
			if (!count_mode)
				crc = {crc[6:0], 1'b0} ^ ((msg[i] ^ crc[7]) ? 8'h0d : 8'h00);
			else if (i >= 4)
				crc = {2'h0, crc[4:0], 1'b0} ^ ((msg[i] ^ crc[5]) ? 8'h0d : 8'h00);
		end
		bytes.just_ctrl_check_byte = crc;
	end
endmodule

/* File: tb/jcc_codec_properties.sv */
/*
 * jcc_codec_properties: port timing and flag checks of the count codec.
 * assumes one mclk domain; bound to every jcc_codec instance.
 */
`timescale 1ns/10ps
module jcc_codec_properties #(
	parameter int CW = jcc_pkg::CNT_W
) (
	input wire logic                mclk,
	input wire logic                arst_n,
	input wire logic                clk_en,
	input wire logic                count_mode,
	input wire logic                enc_frame,
	input wire logic [CW-1:0]       enc_count,
	input wire logic                dec_frame,
	input wire jcc_pkg::jcc_bytes_s dec_bytes,
	input wire jcc_pkg::jcc_bytes_s enc_bytes,
	input wire logic                enc_valid,
	input wire logic [CW-1:0]       dec_count,
	input wire logic                dec_valid,
	input wire logic                dec_crc_ok,
	input wire logic                dec_synced
);
	// ----------------------------------------------------------------
	// encoder base value mirror
	// ----------------------------------------------------------------
	logic [CW-1:0] ref_r;
	wire           take_e = clk_en && enc_frame;
	wire           take_d = clk_en && dec_frame;
	wire [CW-1:0]  cnt_m  = count_mode ? enc_count & CW'(jcc_pkg::NARROW_BITS) : enc_count;
	wire [CW-1:0]  diff   = cnt_m - ref_r;
	wire [CW-1:0]  ndiff  = ref_r - cnt_m;
	wire [1:0]     flg    = enc_bytes.just_ctrl_byte_b[1:0];
	wire [CW-1:0]  fld    = count_mode ? CW'({enc_bytes.just_ctrl_byte_a[5:0], enc_bytes.just_ctrl_byte_b[5:2]})
		: CW'({enc_bytes.just_ctrl_byte_a, enc_bytes.just_ctrl_byte_b[7:2]});

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ref_r <= '0;
		else if (take_e)
			ref_r <= cnt_m;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	a_enc_answer: assert property (take_e |=> enc_valid) else $error("encoder answer missing");
	a_enc_cause: assert property (enc_valid && $past(clk_en) |-> $past(enc_frame))
		else $error("encoder pulse without frame");
	a_enc_hold: assert property (!take_e |=> $stable(enc_bytes)) else $error("encoder bytes moved");
	a_dec_answer: assert property (take_d |=> dec_valid) else $error("decoder answer missing");
	a_dec_hold: assert property (!take_d |=> $stable(dec_count) && $stable(dec_crc_ok))
		else $error("decoder result moved");
	a_sync_steady: assert property (!take_d |=> $stable(dec_synced)) else $error("sync state moved");
	a_flags_same: assert property (take_e && diff == 0 |=> flg == 2'h0 && fld == $past(cnt_m))
		else $error("unchanged count sent wrong");
	a_flags_up: assert property (take_e && (diff == 1 || diff == 2) |=> flg == 2'h2)
		else $error("increment flags wrong");
	a_flags_down: assert property (take_e && (ndiff == 1 || ndiff == 2) |=> flg == 2'h1)
		else $error("decrement flags wrong");
	a_flags_jump: assert property (take_e && diff > 2 && ndiff > 2 |=> flg == 2'h3 && fld == $past(cnt_m))
		else $error("large change sent wrong");

	c_jump: cover property (take_e && diff > 2 && ndiff > 2);
	c_sync: cover property ($rose(dec_synced));
	c_bad: cover property (dec_valid && !dec_crc_ok && dec_synced);
endmodule

bind jcc_codec jcc_codec_properties #(.CW(CW)) jcc_codec_properties_inst (
	.mclk, .arst_n, .clk_en, .count_mode, .enc_frame, .enc_count, .dec_frame, .dec_bytes,
	.enc_bytes, .enc_valid, .dec_count, .dec_valid, .dec_crc_ok, .dec_synced
);

/* File: tb/jcc_codec_bench.sv */
/*
 * jcc_codec_bench: directed frames through encoder and decoder of the count codec.
 * assumes jcc_peer_model builds reference bytes and the checker is bound.
 */
`timescale 1ns/10ps
module jcc_codec_bench;
	logic                mclk;
	logic                arst_n;
	logic                clk_en;
	logic                count_mode;
	logic                enc_frame;
	logic [13:0]         enc_count;
	logic                dec_frame;
	jcc_pkg::jcc_bytes_s dec_bytes;
	jcc_pkg::jcc_bytes_s enc_bytes;
	jcc_pkg::jcc_bytes_s p_bytes;
	logic                enc_valid;
	logic [13:0]         dec_count;
	logic                dec_valid;
	logic                dec_crc_ok;
	logic                dec_synced;
	logic [13:0]         p_field;
	logic [1:0]          p_flags;
	logic [13:0]         enc_ref;
	int                  num_errors;
	int                  check_count;

	jcc_codec jcc_codec_inst (.mclk, .arst_n, .clk_en, .count_mode, .enc_frame, .enc_count, .dec_frame,
		.dec_bytes, .enc_bytes, .enc_valid, .dec_count, .dec_valid, .dec_crc_ok, .dec_synced);
	jcc_peer_model jcc_peer_model_inst (.count_mode, .field(p_field), .flags(p_flags), .bytes(p_bytes));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic ok);
		check_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("Error at %0t: output mismatch", $time);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// expected field and flags follow the step size against the last sent count
	task automatic enc_expect(input logic [13:0] c);
		logic [13:0] d;
		int          k;
		d = c - enc_ref;
		k = d == 14'h1 ? 0 : d == 14'h3fff ? 1 : d == 14'h2 ? 2 : d == 14'h3ffe ? 3 : 4;
		@(posedge mclk);
		enc_frame <= 1'b1;
		enc_count <= c;
		@(posedge mclk);
		enc_frame <= 1'b0;
		p_flags = d == 0 ? 2'h0 : k < 4 ? (k[0] ? 2'h1 : 2'h2) : 2'h3;
		p_field = d == 0 ? enc_ref : k < 4 ? enc_ref ^ (count_mode ? jcc_pkg::INV10[k] : jcc_pkg::INV14[k]) : c;
		#1;
		check(enc_valid === 1'b1 && enc_bytes === p_bytes);
		enc_ref = c;
	endtask

	task automatic dec_step(input logic [13:0] f, input logic [1:0] fl, input logic [23:0] flip,
		input logic [13:0] cnt, input logic ok, input logic syn);
		p_field = f;
		p_flags = fl;
		@(posedge mclk);
		dec_frame <= 1'b1;
		dec_bytes <= jcc_pkg::jcc_bytes_s'(p_bytes ^ flip);
		@(posedge mclk);
		dec_frame <= 1'b0;
		#1;
		check(dec_valid === 1'b1 && dec_count === cnt && dec_crc_ok === ok && dec_synced === syn);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_encoder(input logic mode);
		logic [13:0] s14 [7] = '{14'h64, 14'h65, 14'h67, 14'h66, 14'h64, 14'h64, 14'h3e80};
		logic [13:0] s10 [7] = '{14'h3e8, 14'h3e9, 14'h3eb, 14'h3ea, 14'h3e8, 14'h3e8, 14'h3};
		@(posedge mclk);
		count_mode <= mode;
		for (int i = 0; i < 7; i++)
			enc_expect(mode ? s10[i] : s14[i]);
	endtask

	// hunting first: unequal flags must not synchronise
	task automatic test_decoder14;
		@(posedge mclk);
		count_mode <= 1'b0;
		dec_step(14'h12c, 2'h2, 24'h0, 14'h0, 1'b1, 1'b0);
		dec_step(14'h0c8, 2'h0, 24'h0, 14'h0c8, 1'b1, 1'b1);
		dec_step(14'h0c8 ^ jcc_pkg::INV14[0], 2'h2, 24'h0, 14'h0c9, 1'b1, 1'b1);
		dec_step(14'h0c9 ^ jcc_pkg::INV14[3], 2'h1, 24'h1, 14'h0c7, 1'b0, 1'b1);
		dec_step(14'h0c7 ^ jcc_pkg::INV14[1], 2'h1, 24'h10000, 14'h0c6, 1'b0, 1'b1);
		dec_step(14'h0c6 ^ 14'h1234, 2'h0, 24'h1, 14'h0c6, 1'b0, 1'b0);
		dec_step(14'h1388, 2'h3, 24'h0, 14'h1388, 1'b1, 1'b1);
	endtask

	// reserved bits lie outside the crc-6 cover, so flipping one stays good
	task automatic test_decoder10;
		@(posedge mclk);
		count_mode <= 1'b1;
		dec_step(14'h2bc, 2'h0, 24'h0, 14'h2bc, 1'b1, 1'b1);
		dec_step(14'h2bc ^ jcc_pkg::INV10[2], 2'h2, 24'h0, 14'h2be, 1'b1, 1'b1);
		dec_step(14'h2be ^ 14'h0196, 2'h1, 24'h0, 14'h2bc, 1'b1, 1'b1);
		dec_step(14'h2be, 2'h0, 24'h800000, 14'h2be, 1'b1, 1'b1);
		dec_step(14'h2be, 2'h0, 24'h100, 14'h2be, 1'b0, 1'b0);
	endtask

	task automatic test_clk_en;
		// strobes stay up the whole time, so any edge that leaks through shows
		@(posedge mclk);
		clk_en <= 1'b0;
		enc_frame <= 1'b1;
		dec_frame <= 1'b1;
		repeat (3) begin
			@(posedge mclk);
			#1;
			check(enc_valid === 1'b0 && dec_valid === 1'b0);
		end
		@(posedge mclk);
		enc_frame <= 1'b0;
		dec_frame <= 1'b0;
		clk_en <= 1'b1;
	endtask

	task automatic test_reset;
		@(posedge mclk);
		arst_n <= 1'b0;
		count_mode <= 1'b0;
		@(posedge mclk);
		#1;
		check(enc_bytes === '0 && dec_count === '0 && dec_synced === 1'b0 && enc_valid === 1'b0
			&& dec_valid === 1'b0 && dec_crc_ok === 1'b0);
		@(posedge mclk);
		arst_n <= 1'b1;
		enc_ref = '0;
		enc_expect(14'h1);
	endtask

	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		count_mode = 1'b0;
		enc_frame = 1'b0;
		enc_count = '0;
		dec_frame = 1'b0;
		dec_bytes = '0;
		p_field = '0;
		p_flags = '0;
		enc_ref = '0;
		num_errors = 0;
		check_count = 0;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		test_encoder(1'b0);
		test_encoder(1'b1);
		test_decoder14();
		test_decoder10();
		test_clk_en();
		test_reset();
		report_and_stop();
	end
endmodule
